// ==== sampler_pkg.sv ====
// shared constants and types for the delta bit sampler
package sampler_pkg;
	// divide ratio selection codes
	typedef enum logic [1:0] {
		DIV_BY_1 = 2'h0,
		DIV_BY_2 = 2'h1,
		DIV_BY_4 = 2'h3
	} div_sel_type;

	// bipolar output encoding: two opposite-sign states and an idle code
	localparam logic [1:0] BIPOLAR_POS   = 2'h1;
	localparam logic [1:0] BIPOLAR_NEG   = 2'h3;
	localparam logic [1:0] BIPOLAR_IDLE  = 2'h0;
	// overload level codes: low level normal, high level overload
	localparam logic       LEVEL_NORMAL  = 1'h0;
	localparam logic       LEVEL_OVERLOAD = 1'h1;
	// reset values
	localparam logic [2:0] HISTORY_RESET = 3'h0;
	localparam logic [1:0] COUNT_RESET   = 2'h0;
	localparam logic [1:0] FILL_RESET    = 2'h0;
	// sampling clock rate figures (kHz)
	localparam int CLK_KHZ        = 50000;
	localparam int LINK_MAX_KHZ   = 500;
	localparam int LINK_MIN_KHZ   = 1;
	// least high/low time of the fastest incoming clock in system cycles
	localparam int LINK_HALF_CYCLES = CLK_KHZ / (2 * LINK_MAX_KHZ);

	// one sampled word carried through the buffer
	typedef struct packed {
		logic       data_bit;
		logic [1:0] bipolar;
		logic       overload;
	} sample_type;
endpackage

// ==== sample_buffer.sv ====
// two-entry valid/ready buffer for sampled words
`timescale 1ns/1ns
module sample_buffer
	import sampler_pkg::*;
#(
	parameter int DEPTH = 2
) (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire sampler_pkg::sample_type in_word,
	input  wire logic                    in_valid,
	output logic                         in_ready,
	output sampler_pkg::sample_type      out_word,
	output logic                         out_valid,
	input  wire logic                    out_ready
);
	sample_type store_reg [DEPTH];
	logic [1:0] count_reg;
	logic [1:0] count_next;
	logic       rd_ptr_reg;
	logic       wr_ptr_reg;
	wire        push = in_valid && in_ready;
	wire        pop  = out_valid && out_ready;

	// handshakes from fill level
	assign in_ready   = (count_reg != 2'(DEPTH));
	assign out_valid  = (count_reg != 2'h0);
	assign out_word   = store_reg[rd_ptr_reg];
	assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

	// pointers and fill count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg  <= FILL_RESET;
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			if (push) wr_ptr_reg <= ~wr_ptr_reg;
			if (pop) rd_ptr_reg <= ~rd_ptr_reg;
		end
	end

	// storage write
	always_ff @(posedge clk) begin
		if (push) store_reg[wr_ptr_reg] <= in_word;
	end

	a_buffer_no_overfill: assert property (@(posedge clk) disable iff (!rst_n)
		count_reg <= 2'(DEPTH)) else $error("buffer overfilled");
endmodule // sample_buffer

// ==== delta_bit_sampler.sv ====
// delta bit sampler with clock divider and slope overload detect
`timescale 1ns/1ns
// Functional notes
// (R1) capture input each tick, hold until next
// (R2) tick from input clock divided 1/2/4
// (R3) overload when last three samples equal
// (R4) overload output two levels, high means overload
// (R5) each bit on logic and bipolar outputs
// (R6) handles input clocks up to 500 kHz
// (R7) source normally supplies 100 kHz clock
// (R8) reset clears history, divider, overload
module delta_bit_sampler
	import sampler_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     sample_clk_in,
	input  wire logic                     data_in,
	input  wire sampler_pkg::div_sel_type div_sel,
	output logic                          data_out,
	output logic [1:0]                    bipolar_out,
	output logic                          overload_level,
	output sampler_pkg::sample_type       word_out,
	output logic                          word_valid,
	input  wire logic                     word_ready,
	output logic                          word_dropped
);
	// pins share one vector so that one loop synchronises both
	localparam int PIN_COUNT = 2;
	localparam int PIN_CLK   = 0;
	localparam int PIN_DATA  = 1;
	wire  [PIN_COUNT-1:0] pin_raw = {data_in, sample_clk_in};
	wire  [PIN_COUNT-1:0] pin_sync;
	// divider, history and output flops
	logic                 clk_prev_reg;
	logic [1:0]           div_count_reg;
	logic [2:0]           history_reg;
	logic [1:0]           fill_reg;
	logic                 data_out_reg;
	logic [1:0]           bipolar_reg;
	logic                 overload_reg;
	// buffer handshake and checker helpers
	logic                 tick_valid_reg;
	logic                 dropped_reg;
	logic                 buf_ready;
	logic [1:0]           edge_gap_reg;
	logic                 ticked_reg;

	// two flops per pin; only the second one is read by any logic
	for (genvar pin_index = 0; pin_index < PIN_COUNT; pin_index++) begin : g_pin_sync
		logic meta_reg;
		logic sync_reg;
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				meta_reg <= 1'b0;
				sync_reg <= 1'b0;
			end else begin
				meta_reg <= pin_raw[pin_index];
				sync_reg <= meta_reg;
			end
		end
		assign pin_sync[pin_index] = sync_reg;
	end

	// synchronised pins by name
	wire clk_sync  = pin_sync[PIN_CLK];
	wire data_sync = pin_sync[PIN_DATA];

	// edge detector history; resets to the idle low pin level so no false edge follows reset
	always_ff @(posedge clk) begin
		if (!rst_n) clk_prev_reg <= 1'b0;
		else clk_prev_reg <= clk_sync;
	end

	// true when three history bits all agree; shared by the logic and its checks
	function automatic logic all_same(input logic [2:0] bits);
		return (bits == 3'h7) || (bits == 3'h0);
	endfunction

	// rising edge of incoming clock; at 50 MHz a 500 kHz clock gives 50-cycle halves
	wire        link_edge      = clk_sync && !clk_prev_reg; // [R6]
	wire [1:0]  div_mask       = div_sel;                   // 0, 1 or 3
	wire        tick           = link_edge && ((div_count_reg & div_mask) == 2'h0); // [R2]
	wire [2:0]  history_next   = {history_reg[1:0], data_sync};
	wire        all_equal      = all_same(history_next);
	wire        enough_history = (fill_reg >= 2'h2); // [R3] third sample onward

	// divider counts incoming edges
	always_ff @(posedge clk) begin
		if (!rst_n) div_count_reg <= COUNT_RESET; // [R8]
		else if (link_edge) div_count_reg <= div_count_reg + 2'h1; // [R2]
	end

	// checker helper: incoming edges since the last tick, and whether any tick happened
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			edge_gap_reg <= COUNT_RESET;
			ticked_reg   <= 1'b0;
		end else if (tick) begin
			edge_gap_reg <= COUNT_RESET;
			ticked_reg   <= 1'b1;
		end else if (link_edge) begin
			edge_gap_reg <= edge_gap_reg + 2'h1;
		end
	end

	// next values of the output flops and sample count, decoded from the synchronised bit and the sample history
	wire [1:0]  bipolar_next  = data_sync ? BIPOLAR_POS : BIPOLAR_NEG; // [R5]
	wire        overload_next = (enough_history && all_equal) ? LEVEL_OVERLOAD : LEVEL_NORMAL; // [R3] [R4]
	wire [1:0]  fill_next     = (fill_reg == 2'h3) ? fill_reg : fill_reg + 2'h1;

	// history and sample count; the count saturates after the third sample
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			history_reg <= HISTORY_RESET; // [R8]
			fill_reg    <= FILL_RESET;    // [R8]
		end else if (tick) begin
			history_reg <= history_next;
			fill_reg    <= fill_next;
		end
	end

	// output flops change only on a tick and hold in between
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			data_out_reg <= 1'b0;
			bipolar_reg  <= BIPOLAR_IDLE;
			overload_reg <= LEVEL_NORMAL; // [R8]
		end else if (tick) begin
			data_out_reg <= data_sync;     // [R1]
			bipolar_reg  <= bipolar_next;  // [R5]
			overload_reg <= overload_next; // [R3] [R4]
		end
	end

	// one word per tick into the buffer; lost words are flagged
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_valid_reg <= 1'b0;
			dropped_reg    <= 1'b0;
		end else begin
			tick_valid_reg <= tick;
			dropped_reg    <= tick_valid_reg && !buf_ready;
		end
	end

	sample_buffer #(
		.DEPTH(2)
	) u_buffer (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_word  ({data_out_reg, bipolar_reg, overload_reg}),
		.in_valid (tick_valid_reg),
		.in_ready (buf_ready),
		.out_word (word_out),
		.out_valid(word_valid),
		.out_ready(word_ready)
	);

	// outputs come straight from their flops
	assign data_out       = data_out_reg;
	assign bipolar_out    = bipolar_reg;
	assign overload_level = overload_reg;
	assign word_dropped   = dropped_reg;

	// capture on a tick and hold in between
	a_sample_captured: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		tick |=> data_out == $past(data_sync))
		else $error("sample not captured");
	a_data_holds: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		!tick |=> $stable(data_out))
		else $error("data changed without tick");

	// divider ratio, first tick and spacing of ticks
	a_div_by_one: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(div_sel == DIV_BY_1 && link_edge) |-> tick)
		else $error("divide by one missed edge");
	a_div_ratio: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(tick && div_sel == DIV_BY_4) |-> div_count_reg == 2'h0)
		else $error("divide ratio wrong");
	a_first_tick: assert property (@(posedge clk) disable iff (!rst_n) // [R2] [R8]
		(link_edge && !ticked_reg) |-> tick)
		else $error("first edge after reset missed");
	a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(tick && ticked_reg) |-> edge_gap_reg == div_mask)
		else $error("tick spacing wrong");
	a_tick_not_missed: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
		(link_edge && ticked_reg && edge_gap_reg == div_mask) |-> tick)
		else $error("tick missed");

	// slope overload from the last three samples
	a_overload_set: assert property (@(posedge clk) disable iff (!rst_n) // [R3] [R4]
		(tick && fill_reg >= 2'h2 && all_same({history_reg[1:0], data_sync})) |=> overload_level == LEVEL_OVERLOAD)
		else $error("overload missed");
	a_overload_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		(tick && !all_same({history_reg[1:0], data_sync})) |=> overload_level == LEVEL_NORMAL)
		else $error("overload false");
	a_overload_holds: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
		!tick |=> $stable(overload_level))
		else $error("overload changed without tick");
	a_no_early_overload: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
		fill_reg < 2'h3 |-> overload_level == LEVEL_NORMAL)
		else $error("early overload");

	// bipolar form and the buffered word
	a_bipolar_match: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
		fill_reg != 2'h0 |-> bipolar_out == (data_out ? BIPOLAR_POS : BIPOLAR_NEG))
		else $error("bipolar mismatch");
	a_bipolar_holds: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
		!tick |=> $stable(bipolar_out))
		else $error("bipolar changed without tick");
	a_word_queued: assert property (@(posedge clk) disable iff (!rst_n) // [R1]
		(tick_valid_reg && buf_ready) |=> word_valid)
		else $error("sampled word not queued");

	// reset state
	a_reset_quiet: assert property (@(posedge clk) // [R8]
		!rst_n |=> overload_level == LEVEL_NORMAL && fill_reg == 2'h0 && bipolar_out == BIPOLAR_IDLE && !data_out && !word_valid)
		else $error("reset state wrong");

	// main scenarios
	c_overload_seen: cover property (@(posedge clk) disable iff (!rst_n) $rose(overload_level));
	c_overload_gone: cover property (@(posedge clk) disable iff (!rst_n) $fell(overload_level));
	c_div_two_tick: cover property (@(posedge clk) disable iff (!rst_n) tick && div_sel == DIV_BY_2);
	c_div_four_tick: cover property (@(posedge clk) disable iff (!rst_n) tick && div_sel == DIV_BY_4);
	c_word_drop: cover property (@(posedge clk) disable iff (!rst_n) word_dropped);
endmodule // delta_bit_sampler

// ==== comparator_model.sv ====
// zero-crossing comparator model driving the sample clock and data pins
`timescale 1ns/1ns
module comparator_model
	import sampler_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic [15:0] pattern,
	input  wire logic [15:0] half_cycles,
	output logic             sample_clk_in,
	output logic             data_in
);
	int cnt = 0;
	int idx = 0;
	// pin clock stands low outside frames; data moves on falling pin edges
	always @(negedge clk) begin
		if (!run) begin
			cnt <= 0;
			idx <= 1;
			sample_clk_in <= 1'b0;
			data_in <= pattern[0];
		end else if (cnt == int'(half_cycles) - 1) begin
			cnt <= 0;
			sample_clk_in <= !sample_clk_in;
			if (sample_clk_in) begin
				data_in <= pattern[idx[3:0]];
				idx <= idx + 1;
			end
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule // comparator_model

// ==== testbench.sv ====
// self-checking bench for the delta bit sampler
`timescale 1ns/1ns
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
	$display("mismatch %s expected %0h seen %0h", n, e, s); end end
module testbench;
	import sampler_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic run = 1'b0;
	logic [15:0] pattern = 16'h0000;
	logic sclk, din, data_out, overload_level, word_valid, word_dropped;
	logic word_ready = 1'b1;
	logic [1:0] bipolar_out;
	div_sel_type div_sel = DIV_BY_1;
	sample_type word_out, exp_w, got_w;
	sample_type expq[$];
	logic pin_d = 1'b0;
	logic [2:0] hist;
	int failures = 0;
	int total_checks = 0;
	int ratio = 1;
	localparam int NORMAL_KHZ = 100; // customary source clock
	logic [15:0] half = 16'(LINK_HALF_CYCLES);
	int edges, nsamp, due, drops, cycles = 0;
	initial forever #10 clk = !clk;
	comparator_model partner (.clk(clk), .run(run), .pattern(pattern), .half_cycles(half),
		.sample_clk_in(sclk), .data_in(din));
	delta_bit_sampler dut (.clk(clk), .rst_n(rst_n), .sample_clk_in(sclk), .data_in(din), .div_sel(div_sel),
		.data_out(data_out), .bipolar_out(bipolar_out), .overload_level(overload_level), .word_out(word_out),
		.word_valid(word_valid), .word_ready(word_ready), .word_dropped(word_dropped));
	// reference model: every ratio-th pin edge is a sample, checked once settled
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
		pin_d <= sclk;
		if (!rst_n) begin
			{edges, nsamp, due, drops, hist} = 0;
			expq.delete();
		end else begin
			if (sclk && !pin_d) begin
				if (edges % ratio == 0) begin
					hist = {hist[1:0], din};
					nsamp++;
					exp_w = '{din, din ? BIPOLAR_POS : BIPOLAR_NEG, nsamp >= 3 && (hist == 3'h7 || hist == 3'h0)};
					expq.push_back(exp_w);
					due = 8;
				end
				edges++;
			end
			if (due > 0 && --due == 0) begin
				`CHK("data_out", exp_w.data_bit, data_out)
				`CHK("bipolar_out", exp_w.bipolar, bipolar_out)
				`CHK("overload_level", exp_w.overload ? LEVEL_OVERLOAD : LEVEL_NORMAL, overload_level)
			end
			if (word_dropped === 1'b1) begin
				drops++;
				void'(expq.pop_back());
			end
			if (word_valid === 1'b1 && word_ready === 1'b1) begin
				got_w = expq.pop_front();
				`CHK("word_out", got_w, word_out)
			end
		end
	end
	task automatic do_reset();
		rst_n = 1'b0;
		run = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
	endtask
	// one frame of n pin clock periods; rdy low stalls the consumer throughout
	task automatic run_frame(input div_sel_type sel, input int r, input logic [15:0] p, input logic rdy, input int n);
		do_reset();
		`CHK("reset_out", 6'h00, {data_out, bipolar_out, overload_level, word_valid, word_dropped})
		div_sel = sel;
		ratio = r;
		pattern = p;
		word_ready = rdy;
		run = 1'b1;
		repeat (n * 2 * int'(half)) @(negedge clk);
		run = 1'b0;
		word_ready = 1'b1;
		repeat (20) @(negedge clk);
		`CHK("words_left", 0, expq.size())
		`CHK("samples", n / r, nsamp)
	endtask
	task automatic test_reset_values();
		do_reset();
		`CHK("reset_out", 6'h00, {data_out, bipolar_out, overload_level, word_valid, word_dropped})
		$display("test reset_values done");
	endtask
	task automatic test_div1();
		run_frame(DIV_BY_1, 1, 16'h1D3C, 1'b1, 16);
		$display("test div1 done");
	endtask
	task automatic test_div2();
		run_frame(DIV_BY_2, 2, 16'hF0A5, 1'b1, 16);
		$display("test div2 done");
	endtask
	task automatic test_div4();
		run_frame(DIV_BY_4, 4, 16'h0F0F, 1'b1, 16);
		$display("test div4 done");
	endtask
	task automatic test_stall();
		run_frame(DIV_BY_1, 1, 16'h00C5, 1'b0, 8);
		`CHK("dropped", 6, drops)
		$display("test stall done");
	endtask
	task automatic test_normal_clock();
		half = 16'(CLK_KHZ / (2 * NORMAL_KHZ));
		run_frame(DIV_BY_2, 2, 16'h0015, 1'b1, 8);
		half = 16'(LINK_HALF_CYCLES);
		$display("test normal_clock done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk);
		test_reset_values();
		test_div1();
		test_div2();
		test_div4();
		test_stall();
		test_normal_clock();
		tally_and_finish();
	end
endmodule // testbench
